/* File: src/disk_ctl.sv */
/*
 * Fixed-head disk control and transfer logic plus its read-data FIFO.
 * Assumes the processor issues one command per cycle on the command port
 * and services data breaks with a one-cycle acknowledge; track pins are
 * asynchronous to mclk_in and are synchronised here.
 */
// Overview of operation
// - disk, track and word addresses step only during a valid operation
// - stepping past the last disk flags out of disks; tracks switch in gap
// - at valid delimiter, matching adjusted segment address sets address ok
// - half speed uses every second address, quarter speed four revolutions
// - status shows quarter, half speed, busy and writing-a-one bits
// - each valid unadjusted segment address loads the position register
// - function code goes to first buffer; execute copies it to second
// - end or error clears second buffer, first stays for a continue
// - function 00 nothing, 01 read, 10 write, 11 write check
// - third function bit enables the interrupt request
// - read shifts serially, on match copies word out and requests a break
// - write holds channel word until match then shifts it onto the track
// - write check compares bit by bit, mismatch or parity error flags
// - disk flag at end or on error; interrupt needs both enables
// - error bit is OR of error bits, interrupts, skips, stops operation
// - missing track pulses set hardware fault and freeze until clear
// - unserviced transfer request times out into missed-transfer fault
// - only the first of address parity, data parity, lockout sets, bar both parity faults at one delimiter
// - shift pulses come from strobe and delimiter tracks; read steps at delimiter, write and write check step on break acknowledge
// - transfer complete sets at operation end, interrupts and skips
`timescale 1ns/1ps

module word_fifo #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 4
) (
	input wire logic mclk_in,
	input wire logic srst_in,
	input wire logic flush_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr_ff;
	logic [PW-1:0] rd_ptr_ff;
	logic [PW:0] count_ff;
	logic push;
	logic pop;

	assign in_ready_out = count_ff != (PW+1)'(DEPTH);
	assign out_valid_out = count_ff != '0;
	assign out_data_out = mem[rd_ptr_ff];
	assign push = in_valid_in & in_ready_out;
	assign pop = out_valid_out & out_ready_in;

	always_ff @(posedge mclk_in) begin
		if (push) begin
			mem[wr_ptr_ff] <= in_data_in;
		end
		if (srst_in | flush_in) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
		end else begin
			if (push) begin
				wr_ptr_ff <= (wr_ptr_ff == PW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
			end
			if (pop) begin
				rd_ptr_ff <= (rd_ptr_ff == PW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
			end
			count_ff <= count_ff + (PW+1)'(push) - (PW+1)'(pop);
		end
	end
endmodule // word_fifo

module disk_ctl #(
	parameter int MXF_CYCLES = disk_ctl_pkg::MXF_TIMEOUT_CYC,
	parameter int FIFO_DEPTH = disk_ctl_pkg::FIFO_DEPTH
) (
	input wire logic mclk_in,
	input wire logic srst_in,
	input wire logic system_clear_all_in,
	input wire disk_ctl_pkg::cmd_t cmd_code_in,
	input wire logic [17:0] cmd_data_in,
	output logic [17:0] cmd_rdata_out,
	output logic skip_out,
	input wire logic cpu_int_enable_in,
	output logic int_req_out,
	output logic break_req_out,
	output logic break_to_mem_out,
	input wire logic break_ack_in,
	input wire logic [17:0] break_wdata_in,
	output logic [17:0] break_rdata_out,
	input wire logic overflow_in,
	input wire logic timing_track_in,
	input wire logic address_track_in,
	input wire logic delimiter_track_in,
	input wire logic read_data_in,
	input wire logic gap_in,
	input wire logic write_protect_in,
	input wire logic half_speed_sel_in,
	input wire logic quarter_speed_sel_in,
	input wire logic [7:0] disk_present_in,
	output logic write_gate_out,
	output logic write_data_out,
	output logic [2:0] disk_select_out,
	output logic [6:0] track_select_out
);
	localparam int MW = $clog2(MXF_CYCLES + 1);

	typedef struct packed {
		logic [disk_ctl_pkg::SYNC_W-1:0] sync1;
		logic [disk_ctl_pkg::SYNC_W-1:0] sync2;
		logic [disk_ctl_pkg::SYNC_W-1:0] prev;
		logic [2:0] func1;
		logic [1:0] func2;
		logic [2:0] disk;
		logic [6:0] track;
		logic [10:0] word;
		logic out_of_disks;
		logic [2:0] disk_sel;
		logic [6:0] track_sel;
		logic [12:0] seg_shift;
		logic [3:0] addr_cnt;
		logic [10:0] position;
		logic addr_ok;
		logic [18:0] data_shift;
		logic [4:0] bit_cnt;
		logic [17:0] buf_word;
		logic [10:0] buf_addr;
		logic buf_full;
		logic [18:0] wr_shift;
		logic writing;
		logic timing_track_fault;
		logic address_parity_fault;
		logic missed_transfer_fault;
		logic wce;
		logic data_parity_fault;
		logic write_protect_violation;
		logic ned;
		logic dch;
		logic pge;
		logic transfer_complete;
		logic frozen;
		logic [8:0] strobe_wd;
		logic [MW-1:0] mxf_cnt;
		logic [17:0] rdata;
	} state_t;

	state_t s_ff;
	state_t nxt_s;
	logic raw_strobe;
	logic strobe;
	logic delim;
	logic gap_rise;
	logic busy;
	logic err;
	logic fifo_ready;
	logic fifo_valid;
	logic [17:0] fifo_data;
	logic push;
	logic wr_need;
	logic adv;
	logic [10:0] adj_addr;
	logic [17:0] status;
	logic first_ok;

	function automatic logic [10:0] interlace(input logic [10:0] a, input logic half, input logic quarter);
		if (quarter) begin
			return {a[1:0], a[10:2]};
		end else if (half) begin
			return {a[0], a[10:1]};
		end
		return a;
	endfunction

	function automatic logic rising(input state_t st, input int lane);
		return st.sync2[lane] & ~st.prev[lane];
	endfunction

	assign busy = s_ff.func2 != disk_ctl_pkg::FN_NONE;
	assign err = s_ff.timing_track_fault | s_ff.address_parity_fault | s_ff.missed_transfer_fault | s_ff.wce | s_ff.data_parity_fault | s_ff.write_protect_violation | s_ff.ned;
	assign wr_need = busy & s_ff.func2[1] & ~s_ff.buf_full & ~s_ff.frozen;
	assign break_req_out = fifo_valid | wr_need;
	assign break_to_mem_out = fifo_valid;
	assign break_rdata_out = fifo_data;
	assign skip_out = err | s_ff.transfer_complete;
	assign int_req_out = (err | s_ff.transfer_complete) & s_ff.func1[disk_ctl_pkg::FN_IE_POS] & cpu_int_enable_in;
	assign write_gate_out = s_ff.writing & (s_ff.func2 == disk_ctl_pkg::FN_WRITE) & ~s_ff.frozen;
	assign write_data_out = s_ff.wr_shift[18];
	assign disk_select_out = s_ff.disk_sel;
	assign track_select_out = s_ff.track_sel;
	assign cmd_rdata_out = s_ff.rdata;

	always_comb begin
		status = disk_ctl_pkg::STATUS_RESET;
		status[disk_ctl_pkg::ST_ERR_POS] = err;
		status[disk_ctl_pkg::ST_HDW_POS] = s_ff.timing_track_fault;
		status[disk_ctl_pkg::ST_APE_POS] = s_ff.address_parity_fault;
		status[disk_ctl_pkg::ST_MXF_POS] = s_ff.missed_transfer_fault;
		status[disk_ctl_pkg::ST_WCE_POS] = s_ff.wce;
		status[disk_ctl_pkg::ST_DPE_POS] = s_ff.data_parity_fault;
		status[disk_ctl_pkg::ST_WLO_POS] = s_ff.write_protect_violation;
		status[disk_ctl_pkg::ST_NED_POS] = s_ff.ned;
		status[disk_ctl_pkg::ST_DCH_POS] = s_ff.dch;
		status[disk_ctl_pkg::ST_PGE_POS] = s_ff.pge;
		status[disk_ctl_pkg::ST_XFC_POS] = s_ff.transfer_complete;
		status[disk_ctl_pkg::ST_QUARTER_POS] = s_ff.sync2[disk_ctl_pkg::SI_QUARTER];
		status[disk_ctl_pkg::ST_HALF_POS] = s_ff.sync2[disk_ctl_pkg::SI_HALF];
		status[disk_ctl_pkg::ST_BUSY_POS] = busy;
		status[disk_ctl_pkg::ST_ONE_POS] = write_gate_out & s_ff.wr_shift[18];
	end

	always_comb begin
		nxt_s = s_ff;
		push = 1'b0;
		adv = 1'b0;
		nxt_s.sync1 = {disk_present_in, quarter_speed_sel_in, half_speed_sel_in, write_protect_in, gap_in,
			read_data_in, delimiter_track_in, address_track_in, timing_track_in};
		nxt_s.sync2 = s_ff.sync1;
		nxt_s.prev = s_ff.sync2;
		raw_strobe = rising(s_ff, disk_ctl_pkg::SI_TIM);
		strobe = raw_strobe & ~s_ff.frozen;
		delim = rising(s_ff, disk_ctl_pkg::SI_DLM) & ~s_ff.frozen;
		gap_rise = rising(s_ff, disk_ctl_pkg::SI_GAP);
		adj_addr = interlace(s_ff.seg_shift[12:2], s_ff.sync2[disk_ctl_pkg::SI_HALF],
			s_ff.sync2[disk_ctl_pkg::SI_QUARTER]);
		first_ok = ~(s_ff.address_parity_fault | s_ff.data_parity_fault | s_ff.write_protect_violation);

		case (cmd_code_in)
			disk_ctl_pkg::CMD_LOAD_FUNC: begin
				nxt_s.func1 = cmd_data_in[disk_ctl_pkg::FN_HI_POS:disk_ctl_pkg::FN_IE_POS];
			end
			disk_ctl_pkg::CMD_EXECUTE: begin
				if (!s_ff.frozen) begin
					{nxt_s.missed_transfer_fault, nxt_s.wce, nxt_s.data_parity_fault, nxt_s.write_protect_violation, nxt_s.ned} = '0;
					{nxt_s.dch, nxt_s.pge, nxt_s.transfer_complete} = '0;
					nxt_s.func2 = s_ff.func1[disk_ctl_pkg::FN_HI_POS:disk_ctl_pkg::FN_LO_POS];
					nxt_s.ned = ~s_ff.sync2[disk_ctl_pkg::SI_DISK + 32'(s_ff.disk)];
				end
			end
			disk_ctl_pkg::CMD_LOAD_ADDR: begin
				if (busy) begin
					nxt_s.pge = 1'b1;
				end else begin
					nxt_s.track = cmd_data_in[17:11];
					nxt_s.word = cmd_data_in[10:0];
				end
			end
			disk_ctl_pkg::CMD_LOAD_DISK: begin
				if (busy) begin
					nxt_s.pge = 1'b1;
				end else begin
					nxt_s.disk = cmd_data_in[2:0];
					nxt_s.out_of_disks = 1'b0;
				end
			end
			disk_ctl_pkg::CMD_READ_STATUS: nxt_s.rdata = status;
			disk_ctl_pkg::CMD_READ_POSITION: nxt_s.rdata = {7'h00, s_ff.position};
			disk_ctl_pkg::CMD_READ_ADDR: nxt_s.rdata = {s_ff.track, s_ff.word};
			disk_ctl_pkg::CMD_READ_DISK: nxt_s.rdata = {14'h0000, s_ff.out_of_disks, s_ff.disk};
			default: begin
			end
		endcase

		// serial assembly of address and data tracks
		if (strobe) begin
			if (s_ff.addr_cnt < 4'(disk_ctl_pkg::ADDR_BITS)) begin
				nxt_s.seg_shift = {s_ff.seg_shift[11:0], s_ff.sync2[disk_ctl_pkg::SI_ADR]};
				nxt_s.addr_cnt = s_ff.addr_cnt + 4'h1;
			end
			if (s_ff.bit_cnt < 5'(disk_ctl_pkg::DATA_PAR_BITS)) begin
				nxt_s.data_shift = {s_ff.data_shift[17:0], s_ff.sync2[disk_ctl_pkg::SI_RD]};
				nxt_s.wr_shift = {s_ff.wr_shift[17:0], 1'b0};
				if (s_ff.writing && s_ff.func2 == disk_ctl_pkg::FN_WCHK && first_ok &&
					s_ff.bit_cnt < 5'(disk_ctl_pkg::DATA_BITS) &&
					s_ff.wr_shift[18] != s_ff.sync2[disk_ctl_pkg::SI_RD]) begin
					nxt_s.wce = 1'b1;
				end
			end else if (s_ff.bit_cnt == 5'(disk_ctl_pkg::DATA_PAR_BITS)) begin
				nxt_s.writing = 1'b0;
			end
			if (s_ff.bit_cnt != 5'(disk_ctl_pkg::MAX_BITS_NO_DELIM)) begin
				nxt_s.bit_cnt = s_ff.bit_cnt + 5'h01;
			end else if (busy) begin
				nxt_s.timing_track_fault = 1'b1;
			end
		end

		// missing strobe watchdog, quiet through the gap
		if (raw_strobe || !busy || s_ff.sync2[disk_ctl_pkg::SI_GAP]) begin
			nxt_s.strobe_wd = '0;
		end else if (s_ff.strobe_wd == 9'(disk_ctl_pkg::STROBE_TIMEOUT_CYC)) begin
			nxt_s.timing_track_fault = 1'b1;
		end else begin
			nxt_s.strobe_wd = s_ff.strobe_wd + 9'h001;
		end

		if (delim) begin
			nxt_s.addr_cnt = '0;
			nxt_s.bit_cnt = '0;
			nxt_s.addr_ok = 1'b0;
			// word that just passed the head
			if (s_ff.addr_ok && s_ff.func2 == disk_ctl_pkg::FN_READ) begin
				if (fifo_ready) begin
					push = 1'b1;
					adv = 1'b1;
				end else begin
					nxt_s.dch = 1'b1;
				end
			end
			if (s_ff.addr_ok && s_ff.func2[0] && !(^s_ff.data_shift) && first_ok) begin
				nxt_s.data_parity_fault = 1'b1;
			end
			// address of the word about to pass
			if (s_ff.addr_cnt != 4'(disk_ctl_pkg::ADDR_BITS)) begin
				if (busy) begin
					nxt_s.timing_track_fault = 1'b1;
				end
			end else if (!(^s_ff.seg_shift)) begin
				if (busy && first_ok) begin
					nxt_s.address_parity_fault = 1'b1;
				end
			end else if (s_ff.seg_shift[1]) begin
				nxt_s.position = s_ff.seg_shift[12:2];
				if (busy) begin
					if (s_ff.func2 == disk_ctl_pkg::FN_READ) begin
						nxt_s.addr_ok = adj_addr == s_ff.word;
					end else if (s_ff.buf_full && adj_addr == s_ff.buf_addr) begin
						nxt_s.addr_ok = 1'b1;
						nxt_s.buf_full = 1'b0;
						nxt_s.wr_shift = {s_ff.buf_word, ~(^s_ff.buf_word)};
						if (s_ff.func2 == disk_ctl_pkg::FN_WRITE && s_ff.sync2[disk_ctl_pkg::SI_WP]) begin
							nxt_s.write_protect_violation = first_ok;
						end else begin
							nxt_s.writing = 1'b1;
						end
					end
				end
			end
		end

		// channel word taken for write or write check
		if (wr_need && break_ack_in && !fifo_valid) begin
			nxt_s.buf_word = break_wdata_in;
			nxt_s.buf_addr = s_ff.word;
			nxt_s.buf_full = 1'b1;
			adv = 1'b1;
		end

		// unserviced break request timer
		if (break_req_out && !break_ack_in) begin
			if (s_ff.mxf_cnt == MW'(MXF_CYCLES)) begin
				nxt_s.missed_transfer_fault = 1'b1;
			end else begin
				nxt_s.mxf_cnt = s_ff.mxf_cnt + 1'b1;
			end
		end else begin
			nxt_s.mxf_cnt = '0;
		end

		if (adv && busy) begin
			nxt_s.word = s_ff.word + 11'h001;
			if (s_ff.word == 11'h7FF) begin
				nxt_s.track = s_ff.track + 7'h01;
				if (s_ff.track == 7'h7F) begin
					nxt_s.disk = s_ff.disk + 3'h1;
					if (s_ff.disk == 3'h7 || !s_ff.sync2[disk_ctl_pkg::SI_DISK + 32'(s_ff.disk) + 1]) begin
						nxt_s.ned = 1'b1;
						nxt_s.out_of_disks = s_ff.disk == 3'h7;
					end
				end
			end
		end

		if (gap_rise || !busy) begin
			nxt_s.track_sel = s_ff.track;
			nxt_s.disk_sel = s_ff.disk;
		end

		if (busy && overflow_in) begin
			nxt_s.transfer_complete = 1'b1;
		end
		if (nxt_s.timing_track_fault || nxt_s.address_parity_fault) begin
			nxt_s.frozen = 1'b1;
			nxt_s.writing = 1'b0;
		end
		if (nxt_s.timing_track_fault | nxt_s.address_parity_fault | nxt_s.missed_transfer_fault | nxt_s.wce | nxt_s.data_parity_fault | nxt_s.write_protect_violation | nxt_s.ned | nxt_s.transfer_complete) begin
			nxt_s.func2 = disk_ctl_pkg::FN_NONE;
			nxt_s.writing = 1'b0;
			nxt_s.addr_ok = 1'b0;
		end

		if (cmd_code_in == disk_ctl_pkg::CMD_CLEAR || system_clear_all_in) begin
			nxt_s = '0;
			nxt_s.sync1 = s_ff.sync1;
			nxt_s.sync2 = s_ff.sync2;
			nxt_s.prev = s_ff.prev;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	word_fifo #(
		.WIDTH(disk_ctl_pkg::WORD_W),
		.DEPTH(FIFO_DEPTH)
	) word_fifo_inst (
		.mclk_in(mclk_in),
		.srst_in(srst_in),
		.flush_in(cmd_code_in == disk_ctl_pkg::CMD_CLEAR || system_clear_all_in),
		.in_valid_in(push),
		.in_ready_out(fifo_ready),
		.in_data_in(s_ff.data_shift[18:1]),
		.out_valid_out(fifo_valid),
		.out_ready_in(break_ack_in),
		.out_data_out(fifo_data)
	);
endmodule // disk_ctl

/* File: src/disk_ctl_pkg.sv */
/*
 * Shared constants for the fixed-head disk control and transfer block:
 * command codes, function codes, status bit positions and timing counts.
 * Assumes a 100 MHz system clock; bit numbering of words is [17:0] with
 * processor bit 0 at index 17.
 */
package disk_ctl_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int STROBE_PERIOD_NS = 660;
	localparam int STROBE_PERIOD_CYC = (STROBE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_TIMEOUT_CYC = 4 * STROBE_PERIOD_CYC;
	localparam int MXF_TIMEOUT_MS = 130;
	localparam int MXF_TIMEOUT_CYC = MXF_TIMEOUT_MS * (1000000 / CLK_PERIOD_NS);
	localparam int WORD_W = 18;
	localparam int ADDR_BITS = 13;
	localparam int DATA_BITS = 18;
	localparam int DATA_PAR_BITS = 19;
	localparam int MAX_BITS_NO_DELIM = 30;
	localparam int FIFO_DEPTH = 4;
	// function register fields, index of processor bits 15, 16 and 17
	localparam int FN_HI_POS = 2;
	localparam int FN_LO_POS = 1;
	localparam int FN_IE_POS = 0;
	localparam logic [1:0] FN_NONE = 2'h0;
	localparam logic [1:0] FN_READ = 2'h1;
	localparam logic [1:0] FN_WRITE = 2'h2;
	localparam logic [1:0] FN_WCHK = 2'h3;
	// status word positions (processor bit n sits at index 17-n)
	localparam int ST_ERR_POS = 17;
	localparam int ST_HDW_POS = 16;
	localparam int ST_APE_POS = 15;
	localparam int ST_MXF_POS = 14;
	localparam int ST_WCE_POS = 13;
	localparam int ST_DPE_POS = 12;
	localparam int ST_WLO_POS = 11;
	localparam int ST_NED_POS = 10;
	localparam int ST_DCH_POS = 9;
	localparam int ST_PGE_POS = 8;
	localparam int ST_XFC_POS = 7;
	localparam int ST_QUARTER_POS = 6;
	localparam int ST_HALF_POS = 5;
	localparam int ST_BUSY_POS = 4;
	localparam int ST_ONE_POS = 3;
	localparam logic [17:0] STATUS_RESET = 18'h00000;
	// synchroniser lanes
	localparam int SI_TIM = 0;
	localparam int SI_ADR = 1;
	localparam int SI_DLM = 2;
	localparam int SI_RD = 3;
	localparam int SI_GAP = 4;
	localparam int SI_WP = 5;
	localparam int SI_HALF = 6;
	localparam int SI_QUARTER = 7;
	localparam int SI_DISK = 8;
	localparam int SYNC_W = 16;
	typedef enum logic [3:0] {
		CMD_NONE,
		CMD_LOAD_FUNC,
		CMD_EXECUTE,
		CMD_CLEAR,
		CMD_READ_STATUS,
		CMD_LOAD_ADDR,
		CMD_LOAD_DISK,
		CMD_READ_POSITION,
		CMD_READ_ADDR,
		CMD_READ_DISK
	} cmd_t;
endpackage

/* File: sim/disk_ctl_monitor.sv */
/*
 * Port checker for disk_ctl: flag, interrupt, break and read-back relations.
 * Assumes it is bound into disk_ctl with MXF_CYCLES handed on.
 */
`timescale 1ns/1ps
module disk_ctl_monitor #(
	parameter int MXF_CYCLES = 200
) (
	input wire logic mclk_in,
	input wire logic srst_in,
	input wire logic system_clear_all_in,
	input wire disk_ctl_pkg::cmd_t cmd_code_in,
	input wire logic [17:0] cmd_rdata_out,
	input wire logic skip_out,
	input wire logic cpu_int_enable_in,
	input wire logic int_req_out,
	input wire logic break_req_out,
	input wire logic break_to_mem_out,
	input wire logic break_ack_in,
	input wire logic [17:0] break_rdata_out,
	input wire logic write_gate_out
);
	logic clr;
	logic rd_cmd;
	int wait_ff;
	int nxt_wait;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (srst_in);
	assign clr = system_clear_all_in || cmd_code_in == disk_ctl_pkg::CMD_CLEAR;
	assign rd_cmd = cmd_code_in inside {disk_ctl_pkg::CMD_READ_STATUS, disk_ctl_pkg::CMD_READ_POSITION,
		disk_ctl_pkg::CMD_READ_ADDR, disk_ctl_pkg::CMD_READ_DISK};
	// cycles that a break request has waited unanswered
	always_comb begin
		nxt_wait = (break_req_out && !break_ack_in && !clr) ? wait_ff + 1 : 0;
	end
	always_ff @(posedge mclk_in) begin
		wait_ff <= srst_in ? 0 : nxt_wait;
	end
	a_int_flag: assert property (int_req_out |-> skip_out) else $error("interrupt without flag");
	a_int_cpu_off: assert property (!cpu_int_enable_in [*2] |-> !int_req_out) else $error("interrupt while cpu off");
	a_clear_quiet: assert property (clr |=> !skip_out && !int_req_out && !break_req_out && !write_gate_out)
		else $error("clear left activity");
	a_break_hold: assert property (break_req_out && break_to_mem_out && !break_ack_in && !clr
		|=> break_req_out && $stable(break_rdata_out)) else $error("break word dropped");
	a_rdata_hold: assert property (!rd_cmd && !clr |=> $stable(cmd_rdata_out)) else $error("read data moved");
	a_flag_keeps: assert property (skip_out && !clr && cmd_code_in != disk_ctl_pkg::CMD_EXECUTE |=> skip_out)
		else $error("flag lost");
	a_mxf_bound: assert property (wait_ff > MXF_CYCLES + 2 |-> skip_out) else $error("no missed transfer");
	a_err_or: assert property (cmd_code_in == disk_ctl_pkg::CMD_READ_STATUS
		|=> cmd_rdata_out[17] == |cmd_rdata_out[16:10]) else $error("error bit not or");
	a_stat_pad: assert property (cmd_code_in == disk_ctl_pkg::CMD_READ_STATUS |=> cmd_rdata_out[2:0] == 3'h0)
		else $error("status pad set");
	c_break: cover property (break_req_out && break_ack_in);
	c_int: cover property (int_req_out);
	c_mxf: cover property (wait_ff > MXF_CYCLES + 2);
endmodule // disk_ctl_monitor

/* File: sim/chan_model.sv */
/*
 * Data channel model: acknowledges break requests, counts words, pulses overflow.
 * Assumes the bench sets stall and word limit; drives on the falling edge.
 */
`timescale 1ns/1ps
module chan_model (
	input wire logic mclk_in,
	input wire logic srst_in,
	input wire logic stall_in,
	input wire logic [7:0] limit_in,
	input wire logic break_req_in,
	input wire logic break_to_mem_in,
	input wire logic [17:0] break_rdata_in,
	output logic break_ack_out,
	output logic [17:0] break_wdata_out,
	output logic overflow_out,
	output logic [17:0] last_word_out,
	output logic [7:0] count_out
);
	initial begin
		break_ack_out = 1'b0;
		break_wdata_out = 18'h00000;
		overflow_out = 1'b0;
		count_out = 8'h00;
	end
	always @(negedge mclk_in) begin
		overflow_out <= 1'b0;
		if (srst_in || break_ack_out) begin
			break_ack_out <= 1'b0;
			break_wdata_out <= ~break_wdata_out;
			if (!srst_in && count_out == limit_in) begin
				overflow_out <= 1'b1;
			end
		end else if (break_req_in && !stall_in) begin
			break_ack_out <= 1'b1;
			break_wdata_out <= {10'h2A0, count_out};
		end else begin
			// idle data lines keep changing so nothing stale looks valid
			break_wdata_out <= ~break_wdata_out;
		end
	end
	always @(posedge mclk_in) begin
		if (srst_in) begin
			count_out <= 8'h00;
		end else if (break_ack_out && break_req_in) begin
			count_out <= count_out + 8'h01;
			if (break_to_mem_in) begin
				last_word_out <= break_rdata_in;
			end
		end
	end
endmodule // chan_model

/* File: sim/fixed_head_disk_control_transfer_test.sv */
/*
 * Bench for disk_ctl: function table, read transfer, refused load, freeze, timeout,
 * write check, write and half-speed interlace.
 * Assumes the channel model answers breaks; inputs change on the falling edge.
 */
`timescale 1ns/1ps
bind disk_ctl disk_ctl_monitor #(.MXF_CYCLES(MXF_CYCLES)) disk_ctl_monitor_inst (
	.mclk_in(mclk_in), .srst_in(srst_in), .system_clear_all_in(system_clear_all_in),
	.cmd_code_in(cmd_code_in), .cmd_rdata_out(cmd_rdata_out), .skip_out(skip_out),
	.cpu_int_enable_in(cpu_int_enable_in), .int_req_out(int_req_out), .break_req_out(break_req_out),
	.break_to_mem_out(break_to_mem_out), .break_ack_in(break_ack_in), .break_rdata_out(break_rdata_out),
	.write_gate_out(write_gate_out)
);
module fixed_head_disk_control_transfer_test;
	typedef struct packed {logic [17:0] fn; logic h; logic q; logic [17:0] st;} row_t;
	row_t rows [4] = '{'{18'h00000, 1'b0, 1'b0, 18'h00000}, '{18'h00002, 1'b1, 1'b0, 18'h00030},
		'{18'h00004, 1'b0, 1'b1, 18'h00050}, '{18'h00006, 1'b0, 1'b0, 18'h00010}};
	logic mclk_in = 1'b0;
	logic srst_in = 1'b1;
	logic clr_all = 1'b0, cpu_ie = 1'b0, tim = 1'b0, adr = 1'b0, dlm = 1'b0, rdd = 1'b0;
	logic half = 1'b0, quarter = 1'b0, stall = 1'b1;
	disk_ctl_pkg::cmd_t cmd = disk_ctl_pkg::CMD_NONE;
	logic [17:0] cdata = 18'h00000;
	logic [17:0] rdata, brdata, bwdata, word, last;
	logic skip, intr, breq, btm, back, ovf, wgate, wdat;
	logic [7:0] count;
	int err_count = 0, n_checks = 0;
	always #5 mclk_in = ~mclk_in;
	disk_ctl #(.MXF_CYCLES(200)) disk_ctl_inst (.mclk_in(mclk_in), .srst_in(srst_in),
		.system_clear_all_in(clr_all), .cmd_code_in(cmd), .cmd_data_in(cdata), .cmd_rdata_out(rdata),
		.skip_out(skip), .cpu_int_enable_in(cpu_ie), .int_req_out(intr), .break_req_out(breq),
		.break_to_mem_out(btm), .break_ack_in(back), .break_wdata_in(bwdata), .break_rdata_out(brdata),
		.overflow_in(ovf), .timing_track_in(tim), .address_track_in(adr), .delimiter_track_in(dlm),
		.read_data_in(rdd), .gap_in(1'b0), .write_protect_in(1'b0), .half_speed_sel_in(half),
		.quarter_speed_sel_in(quarter), .disk_present_in(8'h01), .write_gate_out(wgate),
		.write_data_out(wdat), .disk_select_out(), .track_select_out());
	chan_model chan_model_inst (.mclk_in(mclk_in), .srst_in(srst_in), .stall_in(stall), .limit_in(8'h01),
		.break_req_in(breq), .break_to_mem_in(btm), .break_rdata_in(brdata), .break_ack_out(back),
		.break_wdata_out(bwdata), .overflow_out(ovf), .last_word_out(last), .count_out(count));
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [17:0] got, input logic [17:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic issue(input disk_ctl_pkg::cmd_t c, input logic [17:0] d);
		@(negedge mclk_in);
		cmd = c;
		cdata = d;
		@(negedge mclk_in);
		cmd = disk_ctl_pkg::CMD_NONE;
	endtask
	task automatic rd(input disk_ctl_pkg::cmd_t c, output logic [17:0] v);
		issue(c, 18'h00000);
		v = rdata;
	endtask
	// one disk segment: 13 address bits and 19 data bits on the strobes, then the delimiter
	task automatic seg(input logic [10:0] a, input logic [17:0] d);
		logic [12:0] ab;
		logic [18:0] db;
		ab = {a, 1'b1, ~^{a, 1'b1}};
		db = {d, ~^d};
		for (int i = 0; i < 19; i++) begin
			@(negedge mclk_in);
			adr = (i < 13) ? ab[12 - i] : 1'b0;
			rdd = db[18 - i];
			repeat (3) @(negedge mclk_in);
			tim = 1'b1;
			repeat (3) @(negedge mclk_in);
			tim = 1'b0;
		end
		repeat (3) @(negedge mclk_in);
		dlm = 1'b1;
		repeat (3) @(negedge mclk_in);
		dlm = 1'b0;
	endtask
	task automatic start(input logic [17:0] a, input logic [17:0] fn);
		issue(disk_ctl_pkg::CMD_LOAD_ADDR, a);
		issue(disk_ctl_pkg::CMD_LOAD_FUNC, fn);
		issue(disk_ctl_pkg::CMD_EXECUTE, 18'h00000);
	endtask
	initial begin
		repeat (20000) @(posedge mclk_in);
		err_count++;
		print_verdict();
	end
	initial begin
		repeat (20) @(negedge mclk_in);
		srst_in = 1'b0;
		rd(disk_ctl_pkg::CMD_READ_STATUS, word);
		chk("reset status", word, 18'h00000);
		chk("reset flags", {16'h0, skip, breq}, 18'h00000);
		foreach (rows[i]) begin
			half = rows[i].h;
			quarter = rows[i].q;
			issue(disk_ctl_pkg::CMD_CLEAR, 18'h00000);
			repeat (4) @(negedge mclk_in);
			start(18'h00000, rows[i].fn);
			rd(disk_ctl_pkg::CMD_READ_STATUS, word);
			chk("table status", word & 18'h20070, rows[i].st);
		end
		$display("test function table done");
		half = 1'b0;
		quarter = 1'b0;
		issue(disk_ctl_pkg::CMD_CLEAR, 18'h00000);
		repeat (4) @(negedge mclk_in);
		stall = 1'b0;
		cpu_ie = 1'b1;
		start(18'h00005, 18'h00003);
		seg(11'h005, 18'h15A5A);
		seg(11'h006, 18'h2C3C3);
		repeat (20) @(negedge mclk_in);
		chk("read word", last, 18'h2C3C3);
		rd(disk_ctl_pkg::CMD_READ_ADDR, word);
		chk("read addr", word, 18'h00006);
		rd(disk_ctl_pkg::CMD_READ_POSITION, word);
		chk("position", word, 18'h00006);
		rd(disk_ctl_pkg::CMD_READ_STATUS, word);
		chk("done status", word, 18'h00080);
		chk("interrupt", {16'h0, skip, intr}, 18'h00003);
		cpu_ie = 1'b0;
		repeat (2) @(negedge mclk_in);
		chk("interrupt off", {17'h0, intr}, 18'h00000);
		$display("test read done");
		issue(disk_ctl_pkg::CMD_CLEAR, 18'h00000);
		start(18'h00010, 18'h00002);
		issue(disk_ctl_pkg::CMD_LOAD_ADDR, 18'h00777);
		rd(disk_ctl_pkg::CMD_READ_ADDR, word);
		chk("busy addr", word, 18'h00010);
		repeat (300) @(negedge mclk_in);
		rd(disk_ctl_pkg::CMD_READ_STATUS, word);
		chk("freeze status", word, 18'h30100);
		issue(disk_ctl_pkg::CMD_EXECUTE, 18'h00000);
		rd(disk_ctl_pkg::CMD_READ_STATUS, word);
		chk("frozen execute", word, 18'h30100);
		issue(disk_ctl_pkg::CMD_CLEAR, 18'h00000);
		rd(disk_ctl_pkg::CMD_READ_STATUS, word);
		chk("unfrozen", word, 18'h00000);
		$display("test freeze done");
		stall = 1'b1;
		start(18'h00005, 18'h00002);
		seg(11'h005, 18'h00000);
		seg(11'h006, 18'h0F0F0);
		repeat (260) @(negedge mclk_in);
		rd(disk_ctl_pkg::CMD_READ_STATUS, word);
		chk("missed status", word, 18'h24000);
		stall = 1'b0;
		repeat (10) @(negedge mclk_in);
		chk("late word", last, 18'h0F0F0);
		clr_all = 1'b1;
		@(negedge mclk_in);
		clr_all = 1'b0;
		rd(disk_ctl_pkg::CMD_READ_STATUS, word);
		chk("cleared", {word[17:1], skip}, 18'h00000);
		$display("test timeout done");
		// channel has served two words so far: it now hands over 2A002, 2A003, 2A004
		start(18'h00005, 18'h00006);
		rd(disk_ctl_pkg::CMD_READ_ADDR, word);
		chk("check addr", word, 18'h00006);
		seg(11'h005, 18'h00000);
		chk("check gate", {17'h0, wgate}, 18'h00000);
		seg(11'h006, 18'h2A002);
		rd(disk_ctl_pkg::CMD_READ_STATUS, word);
		chk("check equal", word, 18'h00010);
		seg(11'h007, 18'h2A000);
		rd(disk_ctl_pkg::CMD_READ_STATUS, word);
		chk("check differ", word, 18'h22000);
		$display("test write check done");
		issue(disk_ctl_pkg::CMD_CLEAR, 18'h00000);
		start(18'h00005, 18'h00004);
		seg(11'h005, 18'h00000);
		chk("write pins", {16'h0, wgate, wdat}, 18'h00003);
		rd(disk_ctl_pkg::CMD_READ_STATUS, word);
		chk("write status", word, 18'h00018);
		$display("test write done");
		half = 1'b1;
		issue(disk_ctl_pkg::CMD_CLEAR, 18'h00000);
		start(18'h00005, 18'h00002);
		// at half speed segment address 00A lands on word 5
		seg(11'h00A, 18'h00000);
		seg(11'h00B, 18'h3C00F);
		repeat (20) @(negedge mclk_in);
		chk("half word", last, 18'h3C00F);
		rd(disk_ctl_pkg::CMD_READ_POSITION, word);
		chk("half position", word, 18'h0000B);
		$display("test interlace done");
		print_verdict();
	end
endmodule // fixed_head_disk_control_transfer_test
